// ===== design/qbsd_array.sv
// Purpose: Storage array of four banks of rows and columns of words
// Assumes: One access per cycle, byte lane write enables
// Notes:   Contents are not reset; read data holds between reads
module qbsd_array import qbsd_pkg::*; #(
    parameter int AW = MEM_AW,
    parameter int DW = DATA_W,
    parameter int LN = LANE_N
) (
    // Clock
    input logic     pclk,
    // Array port
    qbsd_mem_if.mem m
);
    localparam int LW = DW / LN;

    logic [DW-1:0] mem_q [2**AW];
    logic [DW-1:0] rdata_q;

    // Byte lanes are written independently so masked lanes keep old data
    for (genvar l = 0; l < LN; l++) begin : g_lane
        always_ff @(posedge pclk) begin
            if (m.wr_en && m.wr_lane[l]) begin
                mem_q[m.addr][l*LW +: LW] <= m.wdata[l*LW +: LW];
            end
        end
    end

    // Registered read
    always_ff @(posedge pclk) begin
        if (m.rd_en) begin
            rdata_q <= mem_q[m.addr];
        end
    end

    assign m.rdata = rdata_q;
endmodule

// ===== design/qbsd_core.sv
// Purpose: Command and burst access core of a four bank synchronous DRAM
// Assumes: Controller pins are driven from logic on pclk; no pin synchronisers
// Notes:   Burst mode, order, latency and write mode are set over APB
//
// Summary of operation
// RL1: All pins sampled and driven on rising pclk
// RL2: Four banks of 2048 rows by 256 words
// RL3: Access needs activate before read or write
// RL4: Activate takes bank select and row address
// RL5: Read or write takes bank and low column
// RL6: Burst length 1, 2, 4, 8 or page
// RL7: Sequential or interleaved column order selectable
// RL8: Read latency programmable two or three cycles
// RL9: Auto precharge closes row after burst
// RL10: Burst stop or precharge ends burst
// RL11: Burst read with single location write mode
// RL12: Following columns generated inside the core
// RL13: New read or write accepted every cycle
// RL14: Precharge other bank while burst runs
// RL15: Controller refreshes 4096 rows per window
// RL16: Auto refresh, self refresh and power down
// RL17: Bit ten selects auto precharge on access
// RL18: Precharge bit ten high closes all banks
// RL19: Chip select high ignores command pins
// RL20: Byte mask blocks write or floats read
// RL21: Read data exactly latency cycles after command
module qbsd_core import qbsd_pkg::*; (
    // Clock and reset
    input  logic                  pclk,
    input  logic                  presetn,
    // APB slave
    input  logic                  psel,
    input  logic                  penable,
    input  logic                  pwrite,
    input  logic [APB_AW-1:0]     paddr,
    input  logic [31:0]           pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Memory command pins
    input  logic                  cke,
    input  logic                  cs_n,
    input  logic                  ras_n,
    input  logic                  cas_n,
    input  logic                  we_n,
    input  logic [BANK_W-1:0]     bank_select,
    input  logic [ROW_W-1:0]      row_address_bus,
    input  logic [LANE_N-1:0]     byte_lane_mask,
    // Data pins
    input  logic [DATA_W-1:0]     data_io_bus_in,
    output logic [DATA_W-1:0]     data_io_bus_out,
    output logic [LANE_N-1:0]     data_io_bus_oe
);
    // Next column of a burst from its start and beat index
    function automatic logic [COL_W-1:0] col_of(input logic [COL_W-1:0] start,
                                                input logic [8:0] idx,
                                                input logic [8:0] len,
                                                input logic       il);
        logic [COL_W-1:0] m;
        logic [COL_W-1:0] off;
        m   = (len == 9'h000) ? 8'hFF : 8'(len - 9'h001);
        off = (il && len != 9'h000) ? (start ^ idx[7:0]) : 8'(start + idx[7:0]);
        return (start & ~m) | (off & m);
    endfunction

    // Burst length code to beat count, zero meaning a full page
    function automatic logic [8:0] len_of(input logic [2:0] code);
        case (code)
            BL_1:    return 9'h001;
            BL_2:    return 9'h002;
            BL_4:    return 9'h004;
            BL_8:    return 9'h008;
            BL_FULL: return 9'h000;
            default: return 9'h001;
        endcase
    endfunction

    qbsd_mem_if #(.AW(MEM_AW), .DW(DATA_W), .LN(LANE_N)) mem_bus ();

    qbsd_array #(.AW(MEM_AW), .DW(DATA_W), .LN(LANE_N)) u_array (
        .pclk (pclk),
        .m    (mem_bus.mem)
    );

    // Configuration, status and power state
    logic [31:0]           cfg_q;
    logic [31:0]           rfc_q;
    logic [ROW_W-1:0]      ref_row_q;
    logic [8:0]            sref_cnt_q;
    qbsd_pwr_type          pwr_q;
    logic [BANK_N-1:0]     open_q;
    logic [ROW_W-1:0]      row_q [BANK_N];

    // Burst engine state
    logic                  bst_act_q;
    logic                  bst_wr_q;
    logic                  bst_ap_q;
    logic [BANK_W-1:0]     bst_bank_q;
    logic [COL_W-1:0]      bst_start_q;
    logic [8:0]            bst_idx_q;
    logic [8:0]            bst_len_q;

    // Read path pipeline
    logic                  rv0_q;
    logic                  rv1_q;
    logic [DATA_W-1:0]     rd1_q;
    logic [LANE_N-1:0]     mask_q;
    logic [DATA_W-1:0]     dout_q;
    logic [LANE_N-1:0]     oe_q;
    logic [31:0]           prdata_q;

    // Configuration fields
    wire [2:0] cfg_bl = cfg_q[CFG_BL_LSB +: 3];
    wire       cfg_bt = cfg_q[CFG_BT_BIT];
    wire       cfg_cl3 = cfg_q[CFG_CL_LSB +: 3] != CL_2;
    wire       cfg_ws = cfg_q[CFG_WS_BIT];

    // Command decode; deselected or suspended pins are ignored
    wire [2:0] cmd      = {ras_n, cas_n, we_n};
    wire       cmd_sel  = ~cs_n & cke & (pwr_q == PWR_RUN); // RL19 RL1
    wire       is_act   = cmd_sel & (cmd == CMD_ACT);
    wire       is_rd    = cmd_sel & (cmd == CMD_RD);
    wire       is_wr    = cmd_sel & (cmd == CMD_WR);
    wire       is_pre   = cmd_sel & (cmd == CMD_PRE);
    wire       is_bst   = cmd_sel & (cmd == CMD_BST);
    wire       all_idle = (open_q == '0) & ~bst_act_q;
    wire       is_aref  = cmd_sel & (cmd == CMD_REF) & all_idle;
    wire       pre_all  = row_address_bus[10]; // RL18
    wire       sref_in  = ~cs_n & ~cke & (pwr_q == PWR_RUN) & (cmd == CMD_REF) & all_idle;
    wire       pdn_in   = ~cke & (pwr_q == PWR_RUN) & ~sref_in & (cs_n | cmd == CMD_NOP);

    // An access to a closed bank moves no data
    wire       new_rw   = (is_rd | is_wr) & open_q[bank_select]; // RL3 RL13
    wire [8:0] new_len_wr = cfg_ws ? 9'h001 : len_of(cfg_bl); // RL11
    wire [8:0] new_len  = is_wr ? new_len_wr : len_of(cfg_bl); // RL6

    // A precharge naming the burst bank, or a burst stop, cuts the burst
    wire       pre_hits = is_pre & (pre_all | bank_select == bst_bank_q);
    wire       stop_now = is_bst | pre_hits; // RL10

    // Current beat, from the new command or the running burst
    wire              beat_v    = new_rw | (bst_act_q & cke & ~stop_now);
    wire [BANK_W-1:0] cur_bank  = new_rw ? bank_select : bst_bank_q; // RL5
    wire [COL_W-1:0]  cur_start = new_rw ? row_address_bus[COL_W-1:0] : bst_start_q; // RL5
    wire [8:0]        cur_idx   = new_rw ? 9'h000 : bst_idx_q;
    wire [8:0]        cur_len   = new_rw ? new_len : bst_len_q;
    wire              cur_wr    = new_rw ? is_wr : bst_wr_q;
    wire              cur_ap    = new_rw ? row_address_bus[10] : bst_ap_q; // RL17
    wire [8:0]        nxt_idx   = cur_idx + 9'h001; // RL12
    wire              last_beat = beat_v & (cur_len != 9'h000) & (nxt_idx == cur_len);
    wire [COL_W-1:0]  beat_col  = col_of(cur_start, cur_idx, cur_len, cfg_bt); // RL7 RL12
    wire              ap_close  = last_beat & cur_ap; // RL9

    // Array requests; masked lanes keep their contents
    assign mem_bus.addr    = {cur_bank, row_q[cur_bank], beat_col}; // RL2
    assign mem_bus.wr_en   = beat_v & cur_wr;
    assign mem_bus.wr_lane = ~byte_lane_mask; // RL20
    assign mem_bus.wdata   = data_io_bus_in;
    assign mem_bus.rd_en   = beat_v & ~cur_wr;

    // Per bank row state: activate opens, precharge or auto precharge closes
    for (genvar b = 0; b < BANK_N; b++) begin : g_bank
        wire hit_act = is_act & (bank_select == BANK_W'(b)); // RL4
        wire hit_pre = is_pre & (pre_all | bank_select == BANK_W'(b)); // RL14 RL18
        wire hit_ap  = ap_close & (cur_bank == BANK_W'(b)); // RL9
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                open_q[b] <= 1'b0;
                row_q[b]  <= '0;
            end else if (hit_act) begin
                open_q[b] <= 1'b1;
                row_q[b]  <= row_address_bus; // RL4
            end else if (hit_pre || hit_ap) begin
                open_q[b] <= 1'b0;
            end
        end
    end

    // Burst engine; a new access replaces any burst in flight
    always_ff @(posedge pclk or negedge presetn) begin // RL1
        if (!presetn) begin
            bst_act_q   <= 1'b0;
            bst_wr_q    <= 1'b0;
            bst_ap_q    <= 1'b0;
            bst_bank_q  <= '0;
            bst_start_q <= '0;
            bst_idx_q   <= '0;
            bst_len_q   <= '0;
        end else begin
            if (beat_v) begin
                bst_act_q <= ~last_beat; // RL6
                bst_idx_q <= nxt_idx; // RL12
            end else if (stop_now) begin
                bst_act_q <= 1'b0; // RL10
            end
            if (new_rw) begin
                bst_wr_q    <= is_wr; // RL13
                bst_ap_q    <= row_address_bus[10];
                bst_bank_q  <= bank_select;
                bst_start_q <= row_address_bus[COL_W-1:0];
                bst_len_q   <= new_len;
            end
        end
    end

    // Read pipeline: array adds one stage, a second is used at latency three
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rv0_q  <= 1'b0;
            rv1_q  <= 1'b0;
            rd1_q  <= '0;
            mask_q <= '0;
        end else begin
            rv0_q  <= mem_bus.rd_en;
            rv1_q  <= rv0_q;
            rd1_q  <= mem_bus.rdata;
            mask_q <= byte_lane_mask; // RL20
        end
    end

    // Output stage; the read mask acts two cycles after it is sampled
    wire              out_v    = cfg_cl3 ? rv1_q : rv0_q; // RL8
    wire [DATA_W-1:0] out_data = cfg_cl3 ? rd1_q : mem_bus.rdata; // RL8

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout_q <= '0;
            oe_q   <= '0;
        end else begin
            dout_q <= out_data; // RL21
            oe_q   <= {LANE_N{out_v}} & ~mask_q; // RL21 RL20
        end
    end

    assign data_io_bus_out = dout_q;
    assign data_io_bus_oe  = oe_q;

    // Power and refresh; self refresh walks rows on its own timer
    wire sref_tick = (pwr_q == PWR_SELF) & (sref_cnt_q == 9'(SREF_CYC - 1));
    wire ref_step  = is_aref | sref_tick; // RL16

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_q      <= PWR_RUN;
            sref_cnt_q <= '0;
            ref_row_q  <= '0;
            rfc_q      <= '0;
        end else begin
            case (pwr_q)
                PWR_RUN: begin
                    if (sref_in) begin
                        pwr_q <= PWR_SELF; // RL16
                    end else if (pdn_in) begin
                        pwr_q <= PWR_DOWN; // RL16
                    end
                end
                PWR_DOWN: begin
                    if (cke) begin
                        pwr_q <= PWR_RUN;
                    end
                end
                PWR_SELF: begin
                    if (cke) begin
                        pwr_q <= PWR_RUN;
                    end
                end
                default: pwr_q <= PWR_RUN;
            endcase
            sref_cnt_q <= (pwr_q != PWR_SELF || sref_tick) ? 9'h000 : sref_cnt_q + 9'h001;
            if (ref_step) begin
                ref_row_q <= ref_row_q + 11'h001;
                rfc_q     <= rfc_q + 32'h0000_0001;
            end
        end
    end

    // APB decode; zero wait states, read data latched in the setup cycle
    wire hit_cfg  = paddr == CFG_OFS;
    wire hit_stat = paddr == STAT_OFS;
    wire hit_rfc  = paddr == RFC_OFS;
    wire hit_any  = hit_cfg | hit_stat | hit_rfc;
    wire apb_wr   = psel & penable & pwrite & hit_cfg;
    wire [31:0] stat_word = {24'h000000, 2'(pwr_q), bst_wr_q, bst_act_q, open_q};
    wire [31:0] rd_word = hit_cfg  ? cfg_q :
                          hit_stat ? stat_word :
                          hit_rfc  ? rfc_q : 32'h0000_0000;

    // Configuration register; changes are meant to be made with no burst running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q    <= CFG_RESET;
            prdata_q <= '0;
        end else begin
            if (apb_wr) begin
                cfg_q <= pwdata;
            end
            if (psel && !penable && !pwrite) begin
                prdata_q <= rd_word;
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit_any;
endmodule

// ===== inc/qbsd_mem_if.sv
// Purpose: Carrier between the access core and its storage array
// Assumes: Synchronous single port array, one access per cycle
// Notes:   Read data is registered inside the array
interface qbsd_mem_if #(
    parameter int AW = 21,
    parameter int DW = 32,
    parameter int LN = 4
);
    logic          wr_en;
    logic [LN-1:0] wr_lane;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          rd_en;
    logic [DW-1:0] rdata;

    modport ctrl (output wr_en, wr_lane, addr, wdata, rd_en, input rdata);
    modport mem  (input wr_en, wr_lane, addr, wdata, rd_en, output rdata);
endinterface

// ===== inc/qbsd_pkg.sv
// Purpose: Shared constants for the quad bank SDRAM access core
// Assumes: Single 20 MHz clock, APB register access
// Notes:   Array geometry, command codes, register map and timing counts
package qbsd_pkg;
    // Array geometry
    localparam int BANK_W = 2;
    localparam int ROW_W  = 11;
    localparam int COL_W  = 8;
    localparam int DATA_W = 32;
    localparam int LANE_N = 4;
    localparam int BANK_N = 4;
    localparam int MEM_AW = BANK_W + ROW_W + COL_W;

    // Command codes on {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_MODE = 3'h0;
    localparam logic [2:0] CMD_REF  = 3'h1;
    localparam logic [2:0] CMD_PRE  = 3'h2;
    localparam logic [2:0] CMD_ACT  = 3'h3;
    localparam logic [2:0] CMD_WR   = 3'h4;
    localparam logic [2:0] CMD_RD   = 3'h5;
    localparam logic [2:0] CMD_BST  = 3'h6;
    localparam logic [2:0] CMD_NOP  = 3'h7;

    // Register map (byte addresses)
    localparam int         APB_AW   = 8;
    localparam logic [7:0] CFG_OFS  = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] RFC_OFS  = 8'h08;

    // Configuration fields and reset value
    localparam int          CFG_BL_LSB = 0;
    localparam int          CFG_BT_BIT = 3;
    localparam int          CFG_CL_LSB = 4;
    localparam int          CFG_WS_BIT = 9;
    localparam logic [31:0] CFG_RESET  = 32'h0000_0033;

    // Burst length and latency codes
    localparam logic [2:0] BL_1    = 3'h0;
    localparam logic [2:0] BL_2    = 3'h1;
    localparam logic [2:0] BL_4    = 3'h2;
    localparam logic [2:0] BL_8    = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [2:0] CL_2    = 3'h2;

    // Status fields
    localparam int STAT_OPEN_LSB = 0;
    localparam int STAT_BUSY_BIT = 4;
    localparam int STAT_WR_BIT   = 5;
    localparam int STAT_PWR_LSB  = 6;

    // Self refresh pacing: one row per interval, longest time rounds down
    localparam int REFRESH_ROWS      = 4096;
    localparam int REFRESH_WINDOW_MS = 64;
    localparam int CLK_PERIOD_NS     = 50;
    localparam int SREF_CYC          = (REFRESH_WINDOW_MS * 1000000) / REFRESH_ROWS / CLK_PERIOD_NS;

    // Power states
    typedef enum logic [1:0] {PWR_RUN, PWR_DOWN, PWR_SELF} qbsd_pwr_type;
endpackage

// ===== verification/qbsd_core_properties.sv
// Purpose: Pin level checks for the SDRAM access core
// Assumes: Sees only top ports; latency and open banks are rebuilt here
// Notes:   Auto precharge is not tracked, so open banks may be overstated
module qbsd_core_properties import qbsd_pkg::*; (
    // Clock, reset and APB
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    // Memory pins
    input wire logic              cke,
    input wire logic              cs_n,
    input wire logic              ras_n,
    input wire logic              cas_n,
    input wire logic              we_n,
    input wire logic [BANK_W-1:0] bank_select,
    input wire logic [ROW_W-1:0]  row_address_bus,
    input wire logic [LANE_N-1:0] byte_lane_mask,
    input wire logic [LANE_N-1:0] data_io_bus_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       lat2_q;
    logic [3:0] open_q;
    logic       cke_q;
    // Decoded pins; a command right after a low enable is not taken
    wire [2:0] cmd      = {ras_n, cas_n, we_n};
    wire       cmd_ok   = !cs_n && cke && cke_q;
    wire       rd_ok    = cmd_ok && cmd == CMD_RD && open_q[bank_select];
    wire       rd_setup = psel && !penable && !pwrite;
    wire       any_oe   = |data_io_bus_oe;
    wire       mapped   = paddr == CFG_OFS || paddr == STAT_OFS || paddr == RFC_OFS;
    // Shadow of latency setting and open banks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat2_q <= 1'b0;
            open_q <= 4'h0;
            cke_q  <= 1'b1;
        end else begin
            cke_q <= cke;
            if (psel && penable && pwrite && paddr == CFG_OFS) begin
                lat2_q <= pwdata[CFG_CL_LSB +: 3] == CL_2;
            end
            if (cmd_ok && cmd == CMD_ACT) begin
                open_q[bank_select] <= 1'b1;
            end
            if (cmd_ok && cmd == CMD_PRE) begin
                open_q <= row_address_bus[10] ? 4'h0 : open_q & ~(4'h1 << bank_select);
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_err_phase: assert property (pslverr |-> psel && penable)
        else $error("error flag outside access phase");
    a_err_map: assert property (psel && penable |-> pslverr == !mapped)
        else $error("error flag disagrees with address map");
    a_hole_zero: assert property (psel && penable && !pwrite && !mapped |-> prdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    a_prdata_hold: assert property (!$stable(prdata) |-> $past(rd_setup))
        else $error("read data moved without a read");
    a_mask_float: assert property (byte_lane_mask[0] |-> ##2 !data_io_bus_oe[0])
        else $error("masked lane still driven");
    a_read_cl2: assert property (rd_ok && lat2_q |-> ##2 data_io_bus_oe == ~$past(byte_lane_mask, 2))
        else $error("first word late or early at latency two");
    a_read_cl3: assert property (rd_ok && !lat2_q |-> ##3 data_io_bus_oe == ~$past(byte_lane_mask, 2))
        else $error("first word late or early at latency three");
    a_oe_cause: assert property ($rose(any_oe) |-> $past(rd_ok, 2) || $past(rd_ok, 3))
        else $error("data driven without a taken read");
    a_stop_ends: assert property (cmd_ok && cmd == CMD_BST && !lat2_q |-> ##3 !any_oe)
        else $error("burst kept running after stop");
endmodule
bind qbsd_core qbsd_core_properties u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_select(bank_select), .row_address_bus(row_address_bus),
    .byte_lane_mask(byte_lane_mask), .data_io_bus_oe(data_io_bus_oe)
);

// ===== verification/qbsd_ctrl_model.sv
// Purpose: Memory controller model driving command, mask and write data pins
// Assumes: Pins change by non-blocking assignment just after rising pclk
// Notes:   Code bit 4 lowers the clock enable, bit 3 deselects the chip
module qbsd_ctrl_model import qbsd_pkg::*; (
    // Clock
    input  wire logic         pclk,
    // Command and address pins
    output logic              cke,
    output logic              cs_n,
    output logic              ras_n,
    output logic              cas_n,
    output logic              we_n,
    output logic [BANK_W-1:0] bank_select,
    output logic [ROW_W-1:0]  row_address_bus,
    // Mask and write data pins
    output logic [LANE_N-1:0] byte_lane_mask,
    output logic [DATA_W-1:0] data_io_bus_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Deselected and idle at time zero
    initial begin
        {cke, cs_n, ras_n, cas_n, we_n} = 5'h1F;
        {bank_select, row_address_bus, byte_lane_mask, data_io_bus_in} = '0;
    end
    // One command per call, taken at the next edge; callers pass inverted
    // data when not writing, so a stale word never looks valid
    task automatic cmd(input logic [4:0] c, input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] a,
                       input logic [LANE_N-1:0] m, input logic [DATA_W-1:0] d);
        @(posedge pclk);
        cke                  <= ~c[4];
        cs_n                 <= c[3];
        {ras_n, cas_n, we_n} <= c[2:0];
        bank_select          <= b;
        row_address_bus      <= a;
        byte_lane_mask       <= m;
        data_io_bus_in       <= d;
    endtask
endmodule

// ===== verification/quad_bank_sdram_access_core_test.sv
// Purpose: Self-checking bench for the SDRAM access core
// Assumes: Controller model drives memory pins; APB cycles issued here
// Notes:   Expected words are base plus column, laid down by one page write, except column 2 after the masked write
module quad_bank_sdram_access_core_test import qbsd_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] BASE = 32'h1234_5600;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic        cke, cs_n, ras_n, cas_n, we_n;
    logic [1:0]  bank_select;
    logic [10:0] row_address_bus;
    logic [3:0]  byte_lane_mask, data_io_bus_oe;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q, din, dout;
    logic [31:0] exq[$];
    logic [31:0] cfgs[6] = '{32'h33, 32'h3B, 32'h22, 32'h29, 32'h30, 32'h37};
    logic [10:0] cols[6] = '{11'h5, 11'h3, 11'h6, 11'h1, 11'h7, 11'h6};
    int          n_errors, comparisons, len, cl, col;
    // Device and controller
    qbsd_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cke(cke),
        .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select(bank_select),
        .row_address_bus(row_address_bus), .byte_lane_mask(byte_lane_mask), .data_io_bus_in(din),
        .data_io_bus_out(dout), .data_io_bus_oe(data_io_bus_oe));
    qbsd_ctrl_model ctl (.pclk(pclk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .bank_select(bank_select), .row_address_bus(row_address_bus), .byte_lane_mask(byte_lane_mask),
        .data_io_bus_in(din));
    // 20 MHz clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; waits for pready, takes data and error at that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite} <= {1'b1, 1'b0, wr};
        paddr                   <= a;
        pwdata                  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(q, exp);
    endtask
    // Plain command, lanes unmasked, no write data
    task automatic go(input logic [2:0] c, input logic [1:0] b, input logic [10:0] a);
        ctl.cmd({2'b00, c}, b, a, 4'h0, ~din);
    endtask
    // Bank 0 write burst, data rising per beat, ended by a stop
    task automatic wr_burst(input logic [10:0] a, input logic [3:0] m, input int n, input logic [31:0] d);
        for (int k = 0; k < n; k++) begin
            ctl.cmd({2'b00, k == 0 ? CMD_WR : CMD_NOP}, 2'h0, a, m, d + k);
        end
        go(CMD_BST, 2'h0, a);
        go(CMD_NOP, 2'h0, a);
    endtask
    // Read, one more command, then compare exq per beat
    task automatic rd_burst(input logic [1:0] b, input logic [10:0] a, input logic [2:0] c2,
                            input logic [1:0] b2, input logic [10:0] a2, input int c_l);
        go(CMD_RD, b, a);
        go(c2, b2, a2);
        repeat (c_l - 1) @(posedge pclk);
        foreach (exq[i]) begin
            #1 check(dout, exq[i]);
            @(posedge pclk);
        end
        go(CMD_BST, b, a);
        go(CMD_NOP, b, a);
    endtask
    // Verdict and end of run
    task automatic complete_run();
        $display("Mismatches %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Watchdog sized well past the self refresh wait
    initial begin
        repeat (4000) @(posedge pclk);
        n_errors++;
        complete_run();
    end
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr  = 8'h00;
        pwdata = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rreg(CFG_OFS, 32'h33);
        rreg(RFC_OFS, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        check({31'h0, e}, 32'h1);
        go(CMD_ACT, 2'h0, 11'h5);
        go(CMD_ACT, 2'h1, 11'h9);
        go(CMD_NOP, 2'h0, 11'h0);
        rreg(STAT_OFS, 32'h3);
        apb(1'b1, CFG_OFS, 32'h37);
        wr_burst(11'h0, 4'h0, 10, BASE);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, CFG_OFS, cfgs[i]);
            len = (cfgs[i][2:0] == BL_FULL) ? 256 : 1 << cfgs[i][1:0];
            cl  = (cfgs[i][6:4] == CL_2) ? 2 : 3;
            exq.delete();
            for (int k = 0; k < ((len > 8) ? 4 : len); k++) begin
                col = cfgs[i][3] ? (cols[i] ^ k) : ((cols[i] & ~(len - 1)) | ((cols[i] + k) & (len - 1)));
                exq.push_back(BASE + col);
            end
            rd_burst(2'h0, cols[i], (i == 5) ? CMD_PRE : CMD_NOP, 2'h1, 11'h0, cl);
        end
        apb(1'b1, CFG_OFS, 32'h30);
        exq = '{BASE + 2, BASE + 4};
        rd_burst(2'h0, 11'h2, CMD_RD, 2'h0, 11'h4, 3);
        ctl.cmd({2'b01, CMD_RD}, 2'h0, 11'h0, 4'h0, ~din);
        go(CMD_NOP, 2'h0, 11'h0);
        repeat (2) @(posedge pclk);
        #1 check({28'h0, data_io_bus_oe}, 32'h0);
        apb(1'b1, CFG_OFS, 32'h233);
        wr_burst(11'h2, 4'h1, 8, 32'hFFFF_FF00);
        exq = '{BASE, BASE + 1, 32'hFFFF_FF02, BASE + 3, BASE + 4, BASE + 5, BASE + 6, BASE + 7};
        rd_burst(2'h0, 11'h0, CMD_NOP, 2'h0, 11'h0, 3);
        apb(1'b1, CFG_OFS, 32'h30);
        exq = '{BASE + 5};
        rd_burst(2'h0, 11'h405, CMD_NOP, 2'h0, 11'h0, 3);
        rreg(STAT_OFS, 32'h0);
        go(CMD_ACT, 2'h2, 11'h7);
        go(CMD_ACT, 2'h3, 11'h7);
        go(CMD_PRE, 2'h0, 11'h400);
        go(CMD_REF, 2'h0, 11'h0);
        go(CMD_NOP, 2'h0, 11'h0);
        rreg(STAT_OFS, 32'h0);
        rreg(RFC_OFS, 32'h1);
        ctl.cmd({2'b10, CMD_NOP}, 2'h0, 11'h0, 4'h0, ~din);
        rreg(STAT_OFS, 32'h40);
        ctl.cmd({2'b10, CMD_REF}, 2'h0, 11'h0, 4'h0, ~din);
        go(CMD_NOP, 2'h0, 11'h0);
        ctl.cmd({2'b10, CMD_REF}, 2'h0, 11'h0, 4'h0, ~din);
        rreg(STAT_OFS, 32'h80);
        repeat (400) @(posedge pclk);
        rreg(RFC_OFS, 32'h2);
        go(CMD_NOP, 2'h0, 11'h0);
        go(CMD_NOP, 2'h0, 11'h0);
        rreg(STAT_OFS, 32'h0);
        complete_run();
    end
endmodule
